// ### lsw_pkg.sv
// shared constants and types of the lamp switch serial port and mode pin logic
package lsw_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int SPI_FMAX_KHZ = 5000;
  localparam int WDOG_TIMEOUT_US = 32000;
  localparam int WDOG_CYCLES = WDOG_TIMEOUT_US * CLK_MHZ;
  localparam int WDOG_W = 24;
  localparam int SYNC_PULSE_NS = 1000;
  localparam int SYNC_PULSE_CYCLES = (SYNC_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_W = 6;
  localparam int REF_PERIOD_NS = 10000;
  localparam int REF_DIV_CYCLES = (REF_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int REF_DIV_W = 8;
  localparam int PWM_BITS = 8;
  localparam int TICK_W = 15;

  // ****************************************
  // serial frame and buffer
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int BITS_W = 5;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;

  // ****************************************
  // command word layout
  // ****************************************
  localparam int CMD_ADDR_LSB = 12;
  localparam int CMD_DATA_W = 12;
  localparam logic [3:0] ADDR_DUTY_MAX = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h5;
  localparam logic [3:0] ADDR_FEEDBACK = 4'h6;
  localparam int DUTY_LSB = 0;
  localparam int PRESC_LSB = 8;
  localparam int PRESC_W = 3;
  localparam int CTRL_CH_EN_LSB = 0;
  localparam int CTRL_DIR_EN_LSB = 5;
  localparam int CTRL_EXT_BIT = 9;
  localparam int CTRL_SLEEP_BIT = 10;
  localparam int CTRL_EXTCLK_BIT = 11;
  localparam int FB_W = 4;
  localparam int FB_SEL_LSB = 0;
  localparam int FB_SYNC_BIT = 3;
  localparam logic [2:0] FB_TEMP = 3'h5;
  localparam logic [2:0] FB_VBAT = 3'h6;
  localparam logic [2:0] FB_OFF = 3'h7;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [2:0] PRESC_RST = 3'h0;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [3:0] FB_RST = 4'h7;
  localparam logic [6:0] STAT_PAD = 7'h00;

  // ****************************************
  // pin synchroniser lanes
  // ****************************************
  localparam int NUM_CH = 5;
  localparam int NUM_DIR = 4;
  localparam int PIN_SEL = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_RSLP = 3;
  localparam int PIN_FAIL = 4;
  localparam int PIN_MODE = 5;
  localparam int PIN_DIR_LSB = 6;
  localparam int PIN_W = 10;
  localparam logic [9:0] PIN_RST = 10'h009;

  typedef enum logic [1:0] {
    LSW_SLEEP = 2'b00,
    LSW_NORMAL = 2'b01,
    LSW_FAIL = 2'b10
  } lsw_mode_type;

endpackage

// ### lsw_fifo_if.sv
// carrier between the frame receiver and the command buffer
interface lsw_fifo_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [WIDTH-1:0] rdata;
  logic rvalid;
  logic rready;
  modport user (output wdata, output wvalid, input wready, input rdata, input rvalid, output rready);
  modport fifo (input wdata, input wvalid, output wready, output rdata, output rvalid, input rready);
endinterface

// ### lsw_fifo.sv
// command word buffer with valid and ready on both sides
module lsw_fifo
  import lsw_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  lsw_fifo_if.fifo bus
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wptr_q;
  logic [AW:0] rptr_q;
  wire empty = (wptr_q == rptr_q);
  wire full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
  wire do_wr = bus.wvalid && !full;
  wire do_rd = bus.rready && !empty;

  assign bus.wready = !full;
  assign bus.rvalid = !empty;
  assign bus.rdata = mem_q[rptr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (do_wr) wptr_q <= wptr_q + (AW+1)'(1);
      if (do_rd) rptr_q <= rptr_q + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) mem_q[wptr_q[AW-1:0]] <= bus.wdata;
  end

  no_overrun_a: assert property (@(posedge clk) disable iff (!rst_n) full && bus.wvalid |=> $stable(wptr_q))
    else $error("write accepted while full");
  fill_cov_c: cover property (@(posedge clk) disable iff (!rst_n) full && !bus.rready);
endmodule

// ### lsw_top.sv
// serial control port, mode pins and pwm front end of the lamp switch
// Notes on behaviour
// R1: frames are exactly sixteen bits; host keeps serial clock at or below 5 MHz.
// R2: serial clock and data are ignored while select_n is high.
// R3: select_n low opens a transfer, its rising edge completes it.
// R4: serial input is captured on each rising serial clock edge.
// R5: serial output changes on each falling serial clock edge.
// R6: serial output is released to high impedance while select_n is high.
// R7: chained devices feed output into next input, last back to host.
// R8: reset_sleep_n low clears configuration and puts the device to sleep.
// R9: activity on any direct input wakes the device.
// R10: in fail mode direct inputs switch their channels directly.
// R11: in normal mode serial settings choose whether direct inputs act.
// R12: fail request input forces fail mode.
// R13: loss of serial traffic forces fail mode, direct control stays.
// R14: the mode pin reports sleep state.
// R15: an external pwm reference on the mode pin is divided by 256.
// R16: open-drain sense sync tells the host when to convert feedback.
// R17: feedback selector picks a channel current, temperature or battery.
// R18: external switch drive is a plain logic level.
// R19: each channel has an eight-bit duty and its own prescaler.
// R20: serial port is a sixteen-bit shift register, sixteen-clock chain delay.
module lsw_top
  import lsw_pkg::*;
#(
  parameter int WDOG_CYCLES_P = WDOG_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic SELECT_N,
  input wire logic SCLK,
  input wire logic SI,
  output logic SO,
  output logic SO_OE_N,
  input wire logic RESET_SLEEP_N,
  input wire logic [NUM_DIR-1:0] DIRECT_INPUT,
  input wire logic FAIL_REQUEST,
  input wire logic MODE_PIN_I,
  output logic MODE_PIN_O,
  output logic MODE_PIN_OE_N,
  output logic SENSE_SYNC_N_O,
  output logic SENSE_SYNC_N_OE_N,
  output logic [2:0] ANALOG_FEEDBACK_SEL,
  output logic EXTERNAL_SWITCH_DRIVE,
  output logic [NUM_CH-1:0] POWER_CHANNEL,
  output logic FAIL_MODE,
  output logic SLEEP_MODE
);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // ****************************************
  // pin synchronisers
  // ****************************************
  // a lane changes only once stages two and three agree, filtering single-cycle glitches
  function automatic logic [PIN_W-1:0] agree(input logic [PIN_W-1:0] a, input logic [PIN_W-1:0] b,
                                             input logic [PIN_W-1:0] q);
    agree = (a & b) | (q & (a | b));
  endfunction

  function automatic logic [7:0] ch_phase(input logic [TICK_W-1:0] c, input logic [PRESC_W-1:0] p);
    ch_phase = 8'(c >> p);
  endfunction

  logic [PIN_W-1:0] s1_q, s2_q, s3_q, pin_q, prev_q;
  wire [PIN_W-1:0] pin_raw = {DIRECT_INPUT, MODE_PIN_I, FAIL_REQUEST, RESET_SLEEP_N, SI, SCLK, SELECT_N};

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      s1_q <= PIN_RST;
      s2_q <= PIN_RST;
      s3_q <= PIN_RST;
      pin_q <= PIN_RST;
      prev_q <= PIN_RST;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= agree(s2_q, s3_q, pin_q);
      prev_q <= pin_q;
    end
  end

  wire sel_n = pin_q[PIN_SEL];
  wire sel_fall = prev_q[PIN_SEL] && !sel_n;
  wire sel_rise = !prev_q[PIN_SEL] && sel_n;
  wire sclk_rise = !sel_n && !prev_q[PIN_SCLK] && pin_q[PIN_SCLK]; // R2
  wire sclk_fall = !sel_n && prev_q[PIN_SCLK] && !pin_q[PIN_SCLK]; // R2
  wire si = pin_q[PIN_SI];
  wire rslp_n = pin_q[PIN_RSLP];
  wire fail_req = pin_q[PIN_FAIL];
  wire mode_rise = !prev_q[PIN_MODE] && pin_q[PIN_MODE];
  wire [NUM_DIR-1:0] dir_in = pin_q[PIN_DIR_LSB +: NUM_DIR];

  // ****************************************
  // serial shift register
  // ****************************************
  lsw_mode_type mode_q, mode_d;
  logic [FRAME_BITS-1:0] shreg_q;
  logic [BITS_W-1:0] bits_q;
  logic so_q, frame_bad_q;
  logic [NUM_CH-1:0] pwr_q;
  lsw_fifo_if #(.WIDTH(FIFO_WIDTH)) cmd_if ();

  wire [FRAME_BITS-1:0] status_word = {mode_q, !cmd_if.wready, frame_bad_q, pwr_q, STAT_PAD};
  wire frame_ok = sel_rise && (bits_q == FRAME_LEN);
  wire frame_drop = sel_rise && (bits_q != FRAME_LEN || !cmd_if.wready);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      shreg_q <= '0;
      bits_q <= '0;
      so_q <= 1'b0;
    end else if (sel_fall) begin // R3
      shreg_q <= status_word;
      bits_q <= '0;
      so_q <= status_word[FRAME_BITS-1];
    end else if (sclk_rise) begin // R4 R20
      shreg_q <= {shreg_q[FRAME_BITS-2:0], si};
      if (bits_q != 5'h1f) bits_q <= bits_q + 5'h01;
    end else if (sclk_fall) begin // R5
      so_q <= shreg_q[FRAME_BITS-1];
    end
  end

  // the sticky error bit is cleared when it is loaded out, a new error in that cycle cannot occur
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) frame_bad_q <= 1'b0;
    else if (frame_drop) frame_bad_q <= 1'b1; // R1
    else if (sel_fall) frame_bad_q <= 1'b0;
  end

  // release follows the synchronised select, so the output floats three to four cycles after the pin rises
  assign SO = so_q;
  assign SO_OE_N = sel_n; // R6

  assign cmd_if.wdata = shreg_q;
  assign cmd_if.wvalid = frame_ok; // R3

  ignore_idle_a: assert property (sel_n |=> $stable(shreg_q) && $stable(bits_q)) // R2
    else $error("serial activity taken while deselected");
  shift_in_a: assert property (sclk_rise && !sel_fall |=> shreg_q[0] == $past(si) && // R4
                               shreg_q[FRAME_BITS-1:1] == $past(shreg_q[FRAME_BITS-2:0]))
    else $error("input bit not shifted on rising clock");
  shift_out_a: assert property (sclk_fall && !sel_fall |=> so_q == $past(shreg_q[FRAME_BITS-1])) // R5
    else $error("output bit not updated on falling clock");
  so_release_a: assert property (SELECT_N [*5] |-> SO_OE_N) // R6
    else $error("serial output driven while deselected");
  short_frame_a: assert property (sel_rise && bits_q != FRAME_LEN |=> frame_bad_q) // R1
    else $error("frame of wrong length not flagged");
  frame_cov_c: cover property (sel_fall ##[1:200] frame_ok);

  lsw_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .bus(cmd_if.fifo)
  );

  // ****************************************
  // pwm reference and period
  // ****************************************
  logic [11:0] ctrl_q;
  logic [FB_W-1:0] fb_q;
  logic [7:0] duty_q [NUM_CH];
  logic [PRESC_W-1:0] presc_q [NUM_CH];
  logic [REF_DIV_W-1:0] ref_div_q;
  logic [TICK_W-1:0] tick_q;

  wire extclk_use = ctrl_q[CTRL_EXTCLK_BIT] && (mode_q == LSW_NORMAL);
  wire div_tick = (ref_div_q == REF_DIV_W'(REF_DIV_CYCLES - 1));
  wire ref_tick = extclk_use ? mode_rise : div_tick; // R15
  wire period_start = ref_tick && (tick_q[PWM_BITS-1:0] == 8'hff);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ref_div_q <= '0;
      tick_q <= '0;
    end else begin
      ref_div_q <= div_tick ? '0 : ref_div_q + 8'h01;
      if (ref_tick) tick_q <= tick_q + 15'h0001; // R15
    end
  end

  pwm_wrap_a: assert property (ref_tick && tick_q[PWM_BITS-1:0] == 8'hff |=> tick_q[PWM_BITS-1:0] == 8'h00) // R15
    else $error("pwm period is not 256 reference ticks");

  // ****************************************
  // command decode
  // ****************************************
  // words are applied only at a pwm period start, so the buffer really fills when the host writes fast
  assign cmd_if.rready = period_start && (mode_q != LSW_SLEEP);
  wire apply = cmd_if.rready && cmd_if.rvalid && (mode_q == LSW_NORMAL);
  wire [3:0] cmd_addr = cmd_if.rdata[FRAME_BITS-1:CMD_ADDR_LSB];
  wire [CMD_DATA_W-1:0] cmd_data = cmd_if.rdata[CMD_DATA_W-1:0];
  wire sleep_cmd = apply && (cmd_addr == ADDR_CTRL) && cmd_data[CTRL_SLEEP_BIT];

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N || !rslp_n) begin // R8
      for (int i = 0; i < NUM_CH; i++) begin
        duty_q[i] <= DUTY_RST;
        presc_q[i] <= PRESC_RST;
      end
      ctrl_q <= CTRL_RST;
      fb_q <= FB_RST;
    end else if (apply) begin
      if (cmd_addr <= ADDR_DUTY_MAX) begin // R19
        duty_q[cmd_addr[2:0]] <= cmd_data[DUTY_LSB +: PWM_BITS];
        presc_q[cmd_addr[2:0]] <= cmd_data[PRESC_LSB +: PRESC_W];
      end else if (cmd_addr == ADDR_CTRL) begin // R11 R18
        ctrl_q <= cmd_data;
      end else if (cmd_addr == ADDR_FEEDBACK) begin // R17
        fb_q <= cmd_data[FB_W-1:0];
      end
    end
  end

  // ****************************************
  // mode machine and watchdog
  // ****************************************
  logic [WDOG_W-1:0] wdog_q;
  wire wdog_expired = (wdog_q >= WDOG_W'(WDOG_CYCLES_P - 1));
  wire wake = (|dir_in) || sel_fall;

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      LSW_SLEEP: if (wake) mode_d = fail_req ? LSW_FAIL : LSW_NORMAL; // R9
      LSW_NORMAL: begin
        if (fail_req || wdog_expired) mode_d = LSW_FAIL; // R12 R13
        else if (sleep_cmd) mode_d = LSW_SLEEP;
      end
      LSW_FAIL: if (!fail_req && frame_ok) mode_d = LSW_NORMAL;
      default: mode_d = LSW_SLEEP;
    endcase
    if (!rslp_n) mode_d = LSW_SLEEP; // R8
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mode_q <= LSW_SLEEP;
      wdog_q <= '0;
    end else begin
      mode_q <= mode_d;
      if (frame_ok || mode_q != LSW_NORMAL) wdog_q <= '0; // R13
      else if (!wdog_expired) wdog_q <= wdog_q + 24'h000001;
    end
  end

  reset_sleep_a: assert property (!rslp_n |=> mode_q == LSW_SLEEP && ctrl_q == CTRL_RST && fb_q == FB_RST) // R8
    else $error("reset_sleep_n did not clear and sleep");
  wake_a: assert property (mode_q == LSW_SLEEP && rslp_n && (|dir_in) && !fail_req |=> mode_q == LSW_NORMAL) // R9
    else $error("direct input did not wake");
  fail_force_a: assert property (rslp_n && fail_req && mode_q != LSW_SLEEP |=> mode_q == LSW_FAIL) // R12
    else $error("fail request ignored");
  wdog_fail_a: assert property (rslp_n && mode_q == LSW_NORMAL && wdog_expired |=> mode_q == LSW_FAIL) // R13
    else $error("lost traffic did not enter fail mode");
  fail_cov_c: cover property (mode_q == LSW_NORMAL ##1 mode_q == LSW_FAIL);
  wake_cov_c: cover property (mode_q == LSW_SLEEP ##1 mode_q == LSW_NORMAL);

  // ****************************************
  // channel drive
  // ****************************************
  logic [NUM_CH-1:0] pwr_d;
  logic ext_q, mode_o_q, mode_oe_n_q;
  logic [2:0] fb_sel_q;
  wire [NUM_CH-1:0] ch_en = ctrl_q[CTRL_CH_EN_LSB +: NUM_CH];
  wire [NUM_DIR-1:0] dir_en = ctrl_q[CTRL_DIR_EN_LSB +: NUM_DIR];

  always_comb begin
    pwr_d = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (mode_q == LSW_NORMAL) begin
        pwr_d[i] = ch_en[i] && (ch_phase(tick_q, presc_q[i]) < duty_q[i]); // R19
        if (i < NUM_DIR) pwr_d[i] = pwr_d[i] || (dir_en[i] && dir_in[i]); // R11
      end else if (mode_q == LSW_FAIL && i < NUM_DIR) begin
        pwr_d[i] = dir_in[i]; // R10
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pwr_q <= '0;
      ext_q <= 1'b0;
      fb_sel_q <= FB_OFF;
      mode_o_q <= 1'b0;
      mode_oe_n_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      ext_q <= ctrl_q[CTRL_EXT_BIT] && (mode_q == LSW_NORMAL); // R18
      fb_sel_q <= (mode_q == LSW_SLEEP) ? FB_OFF : fb_q[FB_SEL_LSB +: 3]; // R17
      mode_o_q <= (mode_q != LSW_SLEEP); // R14
      mode_oe_n_q <= extclk_use; // R15
    end
  end

  assign POWER_CHANNEL = pwr_q;
  assign EXTERNAL_SWITCH_DRIVE = ext_q;
  assign ANALOG_FEEDBACK_SEL = fb_sel_q;
  assign MODE_PIN_O = mode_o_q;
  assign MODE_PIN_OE_N = mode_oe_n_q;
  assign FAIL_MODE = (mode_q == LSW_FAIL);
  assign SLEEP_MODE = (mode_q == LSW_SLEEP);

  fail_direct_a: assert property (mode_q == LSW_FAIL |=> POWER_CHANNEL == {1'b0, $past(dir_in)}) // R10
    else $error("fail mode channels do not follow direct inputs");
  dir_gate_a: assert property (mode_q == LSW_NORMAL && ch_en == '0 && dir_en == '0 |=> POWER_CHANNEL == '0) // R11
    else $error("direct inputs act while disabled");
  sleep_pin_a: assert property (mode_q == LSW_SLEEP |=> !MODE_PIN_OE_N && !MODE_PIN_O) // R14
    else $error("mode pin does not report sleep");
  ext_off_a: assert property (mode_q != LSW_NORMAL |=> !EXTERNAL_SWITCH_DRIVE) // R18
    else $error("external switch driven outside normal mode");

  // ****************************************
  // sense sync
  // ****************************************
  // the pulse sits mid on-time of the chosen channel, where its current has settled
  logic [SYNC_W-1:0] sync_q;
  wire [2:0] fb_sel = fb_q[FB_SEL_LSB +: 3];
  wire [2:0] sync_ch = (fb_sel < 3'(NUM_CH)) ? fb_sel : 3'h0;
  wire ch_mid = (fb_sel < 3'(NUM_CH)) && (duty_q[sync_ch] != 8'h00) &&
                (ch_phase(tick_q, presc_q[sync_ch]) == {1'b0, duty_q[sync_ch][7:1]});
  wire aux_mid = (fb_sel == FB_TEMP || fb_sel == FB_VBAT) && (tick_q[PWM_BITS-1:0] == 8'h00);
  wire sync_go = fb_q[FB_SYNC_BIT] && (mode_q == LSW_NORMAL) && ref_tick && (ch_mid || aux_mid);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) sync_q <= '0;
    else if (sync_go) sync_q <= SYNC_W'(SYNC_PULSE_CYCLES); // R16
    else if (sync_q != '0) sync_q <= sync_q - 6'h01;
  end

  assign SENSE_SYNC_N_O = 1'b0;
  assign SENSE_SYNC_N_OE_N = (sync_q == '0); // R16

  sync_width_a: assert property ($fell(SENSE_SYNC_N_OE_N) |-> !SENSE_SYNC_N_OE_N [*8]) // R16
    else $error("sense sync pulse too short");
  sync_cov_c: cover property ($fell(SENSE_SYNC_N_OE_N));
endmodule

// ### lsw_host_model.sv
// host side model: serial master that frames words and reads the serial output back
module lsw_host_model (
  input wire logic clk,
  output logic select_n,
  output logic sclk,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic so_last;
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    select_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    so_last = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  // a released output shows the inverse of its last value, so a stale bit never passes
  function automatic logic so_wire();
    return so_oe_n ? ~so_last : so;
  endfunction
  // ****************************************
  // frames
  // ****************************************
  // eight-cycle phases give 1.25 MHz, leaving room for the pin synchroniser latency
  task automatic frame(input int n, input logic [31:0] w, output logic [31:0] r);
    r = 32'h0;
    hold(1);
    select_n = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      si = w[k];
      hold(8);
      r = {r[30:0], so_wire()};
      if (!so_oe_n) so_last = so;
      sclk = 1'b1;
      hold(8);
      sclk = 1'b0;
    end
    hold(8);
    select_n = 1'b1;
    si = 1'b0;
    hold(8);
  endtask
  // clock and data wiggle with select high; the output must stay released
  task automatic noise(output logic oe_ok);
    oe_ok = 1'b1;
    repeat (8) begin
      sclk = ~sclk;
      si = ~si;
      hold(4);
      if (so_oe_n !== 1'b1) oe_ok = 1'b0;
    end
  endtask
endmodule

// ### tb_top.sv
// self-checking bench of the lamp switch serial port, mode pins and pwm front end
module tb_top
  import lsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WDOG_T = 20000;
  logic clk, rst_n, select_n, sclk, si, so, so_oe_n, rsl_n, fail_req, ref_q, mode_o, mode_oe_n;
  logic sync_o, sync_oe_n, ext_drv, fail_mode, sleep_mode, ok;
  logic [3:0] dir_in;
  logic [2:0] fb_sel, fb_exp;
  logic [4:0] pwr;
  logic [31:0] r;
  int bad_count, check_count, n;
  // host drives the mode pin only while the device has released it
  wire mode_wire = mode_oe_n ? ref_q : mode_o;
  // ****************************************
  // clocks and instances
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    ref_q = 1'b0;
    forever #200 ref_q = ~ref_q;
  end
  lsw_top #(.WDOG_CYCLES_P(WDOG_T)) uut (.CLK_SYS(clk), .RST_N(rst_n), .SELECT_N(select_n), .SCLK(sclk),
    .SI(si), .SO(so), .SO_OE_N(so_oe_n), .RESET_SLEEP_N(rsl_n), .DIRECT_INPUT(dir_in),
    .FAIL_REQUEST(fail_req), .MODE_PIN_I(mode_wire), .MODE_PIN_O(mode_o), .MODE_PIN_OE_N(mode_oe_n),
    .SENSE_SYNC_N_O(sync_o), .SENSE_SYNC_N_OE_N(sync_oe_n), .ANALOG_FEEDBACK_SEL(fb_sel),
    .EXTERNAL_SWITCH_DRIVE(ext_drv), .POWER_CHANNEL(pwr), .FAIL_MODE(fail_mode), .SLEEP_MODE(sleep_mode));
  lsw_host_model host (.clk(clk), .select_n(select_n), .sclk(sclk), .si(si), .so(so), .so_oe_n(so_oe_n));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #5;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return sleep_mode;
      1: return mode_oe_n;
      2: return pwr[0];
      3: return sync_oe_n;
      4: return fail_mode;
      default: return fb_sel === fb_exp;
    endcase
  endfunction
  // live keeps the link busy so the watchdog stays quiet during long waits
  task automatic wait_sig(input int s, input logic v, input int lim, input bit live, output int c);
    logic [31:0] d;
    check_count++;
    for (c = 0; c < lim && sig(s) !== v; c++) begin
      step(1);
      if (live && c % 8000 == 7999) host.frame(16, 32'hf000, d);
    end
    if (sig(s) !== v) begin
      bad_count++;
      $display("Error at %0t: wait on signal %0d ran out", $time, s);
      test_done();
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    chk(32'({so_oe_n, pwr, fb_sel, sleep_mode, mode_o, sync_oe_n, ext_drv}), 32'h107a, "reset");
    host.noise(ok);
    chk(32'(ok), 32'h1, "released output");
    chk(32'(sleep_mode), 32'h1, "asleep after noise");
    $display("test_reset done");
  endtask
  task automatic test_wake();
    dir_in = 4'h2;
    wait_sig(0, 1'b0, 50, 0, n);
    step(2);
    chk(32'(mode_o), 32'h1, "awake flag");
    chk(32'(pwr), 32'h0, "direct input off");
    dir_in = 4'h0;
    host.frame(32, 32'h12340000, r);
    chk(32'(r[31:30]), 32'h1, "normal mode");
    chk(32'(r[15:0]), 32'h1234, "chain echo");
    $display("test_wake done");
  endtask
  task automatic test_config();
    host.frame(16, 32'h5a21, r);
    host.frame(16, 32'h0040, r);
    wait_sig(1, 1'b1, 60000, 1, n);
    step(2);
    chk(32'(ext_drv), 32'h1, "external switch");
    $display("test_config done");
  endtask
  task automatic test_pwm();
    step(2600);
    wait_sig(2, 1'b0, 3000, 0, n);
    wait_sig(2, 1'b1, 3000, 0, n);
    wait_sig(2, 1'b0, 3000, 0, n);
    chk(32'(n), 32'd512, "pwm high time");
    wait_sig(2, 1'b1, 3000, 0, n);
    chk(32'(n), 32'd1536, "pwm low time");
    dir_in = 4'h1;
    step(1000);
    chk(32'(pwr[0]), 32'h1, "direct input on");
    dir_in = 4'h0;
    $display("test_pwm done");
  endtask
  task automatic test_feedback();
    logic [2:0] codes [3];
    codes = '{FB_TEMP, FB_VBAT, 3'h1};
    for (int i = 0; i < 3; i++) begin
      fb_exp = codes[i];
      host.frame(16, 32'({4'h6, 8'h00, 1'b1, codes[i]}), r);
      wait_sig(6, 1'b1, 12000, 0, n);
      if (i == 0) begin
        wait_sig(3, 1'b0, 3000, 0, n);
        wait_sig(3, 1'b1, 100, 0, n);
        chk(32'(n), 32'd20, "sync pulse length");
        chk(32'(sync_o), 32'h0, "open drain data");
      end
    end
    $display("test_feedback done");
  endtask
  task automatic test_buffer();
    repeat (22) host.frame(16, 32'hf000, r);
    host.frame(32, 32'h0, r);
    chk(32'(r[29]), 32'h1, "buffer full");
    chk(32'(r[28]), 32'h1, "frame error");
    $display("test_buffer done");
  endtask
  task automatic test_watchdog();
    wait_sig(4, 1'b1, 25000, 0, n);
    dir_in = 4'h5;
    step(8);
    chk(32'({pwr, ext_drv}), 32'h0a, "fail channels");
    dir_in = 4'h0;
    host.frame(16, 32'hf000, r);
    step(8);
    chk(32'(fail_mode), 32'h0, "fail exit");
    host.frame(32, 32'h0, r);
    chk(32'(r[31:29]), 32'h2, "normal and drained");
    $display("test_watchdog done");
  endtask
  task automatic test_fail_sleep();
    fail_req = 1'b1;
    wait_sig(4, 1'b1, 20, 0, n);
    fail_req = 1'b0;
    rsl_n = 1'b0;
    step(8);
    chk(32'({sleep_mode, mode_o, pwr, fb_sel, ext_drv}), 32'h40e, "sleep reset");
    rsl_n = 1'b1;
    step(4);
    $display("test_fail_sleep done");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    rsl_n = 1'b1;
    fail_req = 1'b0;
    dir_in = 4'h0;
    fb_exp = 3'h0;
    bad_count = 0;
    check_count = 0;
    step(8);
    rst_n = 1'b1;
    step(2);
    test_reset();
    test_wake();
    test_config();
    test_pwm();
    test_feedback();
    test_buffer();
    test_watchdog();
    test_fail_sleep();
    test_done();
  end
endmodule
